// file: hw/cpwm_pkg.sv
// shared constants, types and write carrier for the complementary pwm timer
package cpwm_pkg;

   // pwm_mode_select encodings
   localparam logic [1:0] MODE_TIMER    = 2'h0; // timer / pwm / pwm3
   localparam logic [1:0] MODE_RSYNC    = 2'h1; // reset synchronous pwm
   localparam logic [1:0] MODE_CPWM_UDF = 2'h2; // complementary, load at trough
   localparam logic [1:0] MODE_CPWM_CM  = 2'h3; // complementary, load at peak

   // counter limits and reset values
   localparam logic [15:0] CNT_ZERO   = 16'h0000; // counter floor
   localparam logic [15:0] CNT_ONE    = 16'h0001; // one step
   localparam logic [15:0] CNT_MAX    = 16'hFFFF; // counter ceiling
   localparam logic [15:0] PERIOD_RST = 16'hFFFF; // period after reset
   localparam logic [15:0] GEN_RST    = 16'hFFFF; // general regs after reset
   localparam logic [15:0] BUF_RST    = 16'hFFFF; // buffer regs after reset

   // write select codes on the register write port
   localparam logic [3:0] SEL_PERIOD = 4'h0; // period_compare_a0
   localparam logic [3:0] SEL_GEN    = 4'h1; // general_b0, +1 a1, +2 b1
   localparam logic [3:0] SEL_BUF    = 4'h4; // buffer_d0, +1 c1, +2 d1
   localparam logic [3:0] SEL_CNT0   = 4'h7; // counter_zero
   localparam logic [3:0] SEL_CNT1   = 4'h8; // counter_one

   // flag bit positions in flag_clear
   localparam int FLAG_CMP = 0; // compare_flag_a
   localparam int FLAG_UDF = 1; // underflow_flag
   localparam int FLAG_OVF = 2; // overflow_flag

   // number of buffered channels
   localparam int NCH = 3;

   // one register write
   typedef struct packed {
      logic        we;   // write strobe, one cycle
      logic [3:0]  sel;  // target register
      logic [15:0] data; // value written
   } reg_wr_s;

   // buffer override tracking state
   typedef enum logic [1:0] {
      OVR_NONE,  // selected timing
      OVR_HIGH,  // buffer at or above period
      OVR_ZERO   // buffer equal to zero
   } ovr_state_e;

endpackage : cpwm_pkg

// file: hw/buf_xfer_ctrl.sv
// per-channel decision of when a buffer value moves to its general register
module buf_xfer_ctrl
   import cpwm_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  mode,
   input  wire logic [15:0] buf_val,
   input  wire logic [15:0] period,
   input  wire logic        cm_evt,
   input  wire logic        udf_evt,
   output logic             xfer
);

   ovr_state_e state_reg;   // override tracking
   logic       buf_high;    // buffer at or above period
   logic       buf_zero;    // buffer is zero
   logic       buf_legit;   // 1 .. period-1

   assign buf_high  = (buf_val >= period);
   assign buf_zero  = (buf_val == CNT_ZERO);
   assign buf_legit = !buf_high && !buf_zero;

   // transfer moment per state
   always_comb begin
      unique case (state_reg)
         OVR_HIGH: xfer = udf_evt;
         OVR_ZERO: xfer = cm_evt;
         default:  xfer = (mode == MODE_CPWM_CM) ? cm_evt : udf_evt;
      endcase
   end

   // track overrides, leave after first legal transfer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= OVR_NONE;
      end else if (buf_zero) begin
         state_reg <= OVR_ZERO;
      end else if (buf_high) begin
         state_reg <= OVR_HIGH;
      end else if (buf_legit && xfer) begin
         state_reg <= OVR_NONE;
      end
   end

endmodule // buf_xfer_ctrl

// file: hw/complementary_pwm_timer.sv
// two-counter timer with reset synchronous and complementary pwm modes
module complementary_pwm_timer
   import cpwm_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic                 counter0_run,
   input  wire logic                 counter1_run,
   input  wire logic [1:0]           pwm_mode_select,
   input  wire logic                 pos_phase_init_level,
   input  wire logic                 neg_phase_init_level,
   input  wire logic [NCH-1:0]       buffer_sel,
   input  wire reg_wr_s              reg_wr,
   input  wire logic [2:0]           flag_clear,
   output logic [15:0]               counter_zero,
   output logic [15:0]               counter_one,
   output logic [15:0]               period_compare_a0,
   output logic [NCH-1:0][15:0]      general_out,
   output logic                      compare_flag_a,
   output logic                      underflow_flag,
   output logic                      overflow_flag,
   output logic [NCH-1:0]            pwm_pos,
   output logic [NCH-1:0]            pwm_neg
);

   logic [15:0]           cnt0_reg;     // counter_zero
   logic [15:0]           cnt1_reg;     // counter_one
   logic [15:0]           period_reg;   // peak compare value
   logic                  down_reg;     // complementary count direction
   logic [NCH-1:0][15:0]  gen_reg;      // general compare registers
   logic [NCH-1:0][15:0]  buf_reg;      // buffer registers
   logic                  cmp_reg;      // compare_flag_a
   logic                  udf_reg;      // underflow_flag
   logic                  ovf_reg;      // overflow_flag
   logic [NCH-1:0]        pos_reg;      // positive phase pins
   logic [NCH-1:0]        neg_reg;      // negative phase pins
   logic [NCH-1:0]        xfer;         // per-channel load pulse

   logic                  cpwm;         // complementary mode
   logic                  rsync;        // reset synchronous mode
   logic                  running;      // counting in this mode
   logic [15:0]           peak;         // m+1
   logic                  cm_evt;       // compare match event
   logic                  udf_evt;      // counter_one underflow
   logic                  ovf_evt;      // counter_zero wrap
   logic                  wr_cnt0;      // software writes counter_zero
   logic                  wr_cnt1;      // software writes counter_one

   assign cpwm  = pwm_mode_select[1];
   assign rsync = (pwm_mode_select == MODE_RSYNC);

   // complementary needs both run bits
   assign running = cpwm ? (counter0_run && counter1_run) : counter0_run;
   assign peak    = 16'(period_reg + CNT_ONE);

   // peak event only on the way up, m to m+1
   assign cm_evt = running && (cpwm ? (!down_reg && cnt0_reg == period_reg)
                                    : (cnt0_reg == period_reg));
   // underflow only on the way down, 0 to FFFF
   assign udf_evt = running && cpwm && down_reg && (cnt1_reg == CNT_ZERO);
   // wrap of counter_zero in timer mode only
   assign ovf_evt = running && !cpwm && !rsync && (cnt0_reg == CNT_MAX);

   assign wr_cnt0 = reg_wr.we && reg_wr.sel == SEL_CNT0;
   assign wr_cnt1 = reg_wr.we && reg_wr.sel == SEL_CNT1;

   // counter_zero stepping
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt0_reg <= CNT_ZERO;
      end else if (wr_cnt0) begin
         cnt0_reg <= reg_wr.data;
      end else if (running) begin
         if (cpwm) begin
            if (down_reg || cnt0_reg == peak) begin
               cnt0_reg <= 16'(cnt0_reg - CNT_ONE);
            end else begin
               cnt0_reg <= 16'(cnt0_reg + CNT_ONE);
            end
         end else if (rsync && cnt0_reg == period_reg) begin
            // period match clears in rsync mode
            cnt0_reg <= CNT_ZERO;
         end else begin
            cnt0_reg <= 16'(cnt0_reg + CNT_ONE);
         end
      end
   end

   // counter_one stepping, complementary mode only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt1_reg <= CNT_ZERO;
      end else if (wr_cnt1) begin
         cnt1_reg <= reg_wr.data;
      end else if (running && cpwm) begin
         if (down_reg && cnt1_reg != CNT_MAX) begin
            cnt1_reg <= 16'(cnt1_reg - CNT_ONE);
         end else if (!down_reg && cnt0_reg == peak) begin
            cnt1_reg <= 16'(cnt1_reg - CNT_ONE);
         end else begin
            cnt1_reg <= 16'(cnt1_reg + CNT_ONE);
         end
      end
   end

   // shared direction: down from peak, up from trough
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         down_reg <= 1'b0;
      end else if (!cpwm) begin
         down_reg <= 1'b0;
      end else if (running) begin
         if (!down_reg && cnt0_reg == peak) begin
            down_reg <= 1'b1;
         end else if (down_reg && cnt1_reg == CNT_MAX) begin
            down_reg <= 1'b0;
         end
      end
   end

   // period register, direct write only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         period_reg <= PERIOD_RST;
      // no buffered path into the period
      end else if (reg_wr.we && reg_wr.sel == SEL_PERIOD) begin
         period_reg <= reg_wr.data;
      end
   end

   // per channel buffer, general register and load control
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         // buffer register write
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               buf_reg[ch] <= BUF_RST;
            end else if (reg_wr.we && reg_wr.sel == 4'(SEL_BUF + ch)) begin
               buf_reg[ch] <= reg_wr.data;
            end
         end

         // load timing for this channel
         buf_xfer_ctrl u_xfer (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .mode    (pwm_mode_select),
            .buf_val (buf_reg[ch]),
            .period  (period_reg),
            .cm_evt  (cm_evt),
            .udf_evt (udf_evt),
            .xfer    (xfer[ch])
         );

         // general register: buffered load beats direct write
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               gen_reg[ch] <= GEN_RST;
            end else if (cpwm && buffer_sel[ch] && xfer[ch]) begin
               gen_reg[ch] <= buf_reg[ch];
            end else if (reg_wr.we && reg_wr.sel == 4'(SEL_GEN + ch)) begin
               gen_reg[ch] <= reg_wr.data;
            end
         end

         // pin levels: init level when idle, inverted while active
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               pos_reg[ch] <= 1'b0;
               neg_reg[ch] <= 1'b0;
            end else if (!running || !(cpwm || rsync)) begin
               // stopped or plain mode shows initial levels
               pos_reg[ch] <= pos_phase_init_level;
               neg_reg[ch] <= neg_phase_init_level;
            end else if (cpwm) begin
               // positive off counter_zero, negative off counter_one
               pos_reg[ch] <= pos_phase_init_level
                              ^ (cnt0_reg >= gen_reg[ch]);
               neg_reg[ch] <= neg_phase_init_level
                              ^ (cnt1_reg < gen_reg[ch]);
            end else begin
               // rsync: negative compares with the opposite sense of positive
               pos_reg[ch] <= pos_phase_init_level
                              ^ (cnt0_reg < gen_reg[ch]);
               neg_reg[ch] <= neg_phase_init_level
                              ^ (cnt0_reg >= gen_reg[ch]);
            end
         end
      end
   endgenerate

   // compare flag, set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmp_reg <= 1'b0;
      end else if (cm_evt) begin
         cmp_reg <= 1'b1;
      end else if (flag_clear[FLAG_CMP]) begin
         cmp_reg <= 1'b0;
      end
   end

   // underflow flag, set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         udf_reg <= 1'b0;
      end else if (udf_evt) begin
         udf_reg <= 1'b1;
      end else if (flag_clear[FLAG_UDF]) begin
         udf_reg <= 1'b0;
      end
   end

   // overflow flag, never set in complementary mode
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ovf_reg <= 1'b0;
      end else if (ovf_evt) begin
         ovf_reg <= 1'b1;
      end else if (flag_clear[FLAG_OVF]) begin
         ovf_reg <= 1'b0;
      end
   end

   // outputs straight from flip-flops
   assign counter_zero      = cnt0_reg;
   assign counter_one       = cnt1_reg;
   assign period_compare_a0 = period_reg;
   assign general_out       = gen_reg;
   assign compare_flag_a    = cmp_reg;
   assign underflow_flag    = udf_reg;
   assign overflow_flag     = ovf_reg;
   assign pwm_pos           = pos_reg;
   assign pwm_neg           = neg_reg;

endmodule // complementary_pwm_timer

// file: verif/cpwm_chk.sv
// port-level assertions for the complementary pwm timer
module cpwm_chk
   import cpwm_pkg::*;
(
   input wire logic             sys_clk,
   input wire logic             rst_n,
   input wire logic             counter0_run,
   input wire logic             counter1_run,
   input wire logic [1:0]       pwm_mode_select,
   input wire logic             pos_phase_init_level,
   input wire logic             neg_phase_init_level,
   input wire reg_wr_s          reg_wr,
   input wire logic [2:0]       flag_clear,
   input wire logic [15:0]      counter_zero,
   input wire logic [15:0]      counter_one,
   input wire logic [15:0]      period_compare_a0,
   input wire logic [NCH-1:0][15:0] general_out,
   input wire logic             compare_flag_a,
   input wire logic             underflow_flag,
   input wire logic             overflow_flag,
   input wire logic [NCH-1:0]   pwm_pos,
   input wire logic [NCH-1:0]   pwm_neg
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // complementary counting with no software access
   wire logic go = pwm_mode_select[1] & counter0_run & counter1_run
                   & ~reg_wr.we & ~|flag_clear;
   // counter_zero climbing into the peak
   sequence s_peak;
      go && counter_zero == period_compare_a0 - CNT_ONE
      ##1 go && counter_zero == period_compare_a0;
   endsequence
   // counter_one falling into the trough
   sequence s_trough;
      go && counter_one == CNT_ONE ##1 go && counter_one == CNT_ZERO;
   endsequence
   a_peak_turn: assert property (s_peak |=>
      counter_zero == period_compare_a0 + CNT_ONE
      ##1 counter_zero == period_compare_a0
      ##1 counter_zero == period_compare_a0 - CNT_ONE)
      else $error("peak turn order wrong");
   a_peak_flag: assert property (s_peak |=> compare_flag_a)
      else $error("compare flag not set at peak");
   a_down_quiet: assert property (s_peak ##1 go |=>
      compare_flag_a && $stable(general_out))
      else $error("change on way down");
   a_trough_turn: assert property (s_trough |=>
      counter_one == CNT_MAX ##1 counter_one == CNT_ZERO
      ##1 counter_one == CNT_ONE)
      else $error("trough turn order wrong");
   a_udf_flag: assert property (s_trough |=> underflow_flag)
      else $error("underflow flag not set");
   a_up_quiet: assert property (s_trough ##1 go |=>
      $stable(general_out) && $stable(overflow_flag))
      else $error("change on way up");
   a_period_fixed: assert property (go |=>
      $stable(period_compare_a0) && !$rose(overflow_flag))
      else $error("period or overflow moved");
   a_rsync_wrap: assert property (pwm_mode_select == MODE_RSYNC
      && counter0_run && !reg_wr.we
      && counter_zero == period_compare_a0
      |=> counter_zero == CNT_ZERO && compare_flag_a)
      else $error("rsync wrap wrong");
   a_idle_level: assert property ((pwm_mode_select != MODE_TIMER
      && !counter0_run && !counter1_run) [*2]
      |-> pwm_pos == {NCH{$past(pos_phase_init_level)}}
      && pwm_neg == {NCH{$past(neg_phase_init_level)}})
      else $error("stopped pins not at initial level");
   a_period_wr: assert property (reg_wr.we && reg_wr.sel == SEL_PERIOD
      |=> period_compare_a0 == $past(reg_wr.data))
      else $error("period write lost");
endmodule // cpwm_chk

bind complementary_pwm_timer cpwm_chk chk (
   .sys_clk, .rst_n, .counter0_run, .counter1_run, .pwm_mode_select,
   .pos_phase_init_level, .neg_phase_init_level, .reg_wr, .flag_clear,
   .counter_zero, .counter_one, .period_compare_a0, .general_out,
   .compare_flag_a, .underflow_flag, .overflow_flag, .pwm_pos, .pwm_neg);

// file: verif/motor_stage.sv
// power stage model driven by the pwm pins
module motor_stage
   import cpwm_pkg::*;
(
   input  wire logic           sys_clk,
   input  wire logic [NCH-1:0] pwm_pos,
   input  wire logic [NCH-1:0] pwm_neg,
   output logic      [NCH-1:0] phase_out,
   output int                  edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [NCH-1:0] pos_last = '0; // previous high gate levels
   logic [NCH-1:0] leg_reg  = '0; // leg levels seen by the load
   int             edge_cnt = 0;  // high gate level changes
   // high gate pulls a leg up, low gate down, else it coasts
   always @(posedge sys_clk) begin
      leg_reg <= (pwm_pos & ~pwm_neg) | (leg_reg & ~(pwm_neg & ~pwm_pos));
      if (pwm_pos !== pos_last) begin
         edge_cnt <= edge_cnt + 1;
      end
      pos_last <= pwm_pos;
   end
   // one driver per output
   assign phase_out = leg_reg;
   assign edges     = edge_cnt;
endmodule // motor_stage

// file: verif/tb.sv
// self-checking bench for the complementary pwm timer
module tb
   import cpwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic           sys_clk = 1'b0;
   logic           rst_n = 1'b0;
   logic           counter0_run = 1'b0;
   logic           counter1_run = 1'b0;
   logic [1:0]     pwm_mode_select = MODE_TIMER;
   logic           pos_phase_init_level = 1'b0;
   logic           neg_phase_init_level = 1'b0;
   logic [NCH-1:0] buffer_sel = '0;
   reg_wr_s        reg_wr = '0;
   logic [2:0]     flag_clear = '0;
   logic [15:0]    counter_zero, counter_one, period_compare_a0;
   logic [NCH-1:0][15:0] general_out;
   logic           compare_flag_a, underflow_flag, overflow_flag;
   logic [NCH-1:0] pwm_pos, pwm_neg, phase_out;
   int             edges, miscompares = 0, num_checks = 0;
   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;
   complementary_pwm_timer uut (.sys_clk, .rst_n, .counter0_run,
      .counter1_run, .pwm_mode_select, .pos_phase_init_level,
      .neg_phase_init_level, .buffer_sel, .reg_wr, .flag_clear,
      .counter_zero, .counter_one, .period_compare_a0, .general_out,
      .compare_flag_a, .underflow_flag, .overflow_flag, .pwm_pos, .pwm_neg);
   motor_stage stage (.sys_clk, .pwm_pos, .pwm_neg, .phase_out, .edges);
   // verdict and end of run
   task automatic results();
      if (miscompares == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // compare one value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [3:0] sel, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= '{1'b1, sel, d};
      @(posedge sys_clk);
      reg_wr.we <= 1'b0;
   endtask
   // bounded wait for a counter value
   task automatic wait_for(input logic one, input logic [15:0] v);
      for (int i = 0; i < 200; i++) begin
         @(posedge sys_clk);
         #1;
         if ((one ? counter_one : counter_zero) === v)
            return;
      end
      miscompares++;
      $display("[ERR] %0t counter wait timed out", $time);
      results();
   endtask
   // stop, pass through timer mode, load period and counters
   task automatic cfg(input logic [1:0] m, input logic [15:0] per, c0, c1);
      @(posedge sys_clk);
      counter0_run <= 1'b0;
      counter1_run <= 1'b0;
      @(posedge sys_clk);
      pwm_mode_select <= MODE_TIMER;
      @(posedge sys_clk);
      pwm_mode_select <= m;
      wr(SEL_PERIOD, per);
      wr(SEL_CNT0, c0);
      wr(SEL_CNT1, c1);
      @(posedge sys_clk);
      flag_clear <= 3'h7;
      @(posedge sys_clk);
      flag_clear <= 3'h0;
   endtask
   // complementary run: buffers legal, zero and above period
   task automatic run_cpwm(input logic [1:0] m);
      logic [15:0] bufv [NCH] = '{16'h0003, 16'h0000, 16'h0009};
      cfg(m, 16'h0008, 16'h0005, 16'h0002);
      @(posedge sys_clk);
      buffer_sel <= '0;
      for (int k = 0; k < NCH; k++) begin
         wr(SEL_GEN + 4'(k), 16'h0111);
         wr(SEL_BUF + 4'(k), bufv[k]);
      end
      @(posedge sys_clk);
      buffer_sel <= '1;
      counter0_run <= 1'b1;
      counter1_run <= 1'b1;
      wait_for(1'b0, 16'h0009);
      chk(compare_flag_a, 1'b1);
      chk(general_out[0], m[0] ? 16'h0003 : 16'h0111);
      chk(general_out[1], 16'h0000);
      chk(general_out[2], 16'h0111);
      chk(pwm_pos[2], 1'b1);
      chk(pwm_neg[2], 1'b0);
      wait_for(1'b1, CNT_MAX);
      chk(underflow_flag, 1'b1);
      chk(general_out[0], 16'h0003);
      chk(general_out[2], 16'h0009);
      chk(period_compare_a0, 16'h0008);
      chk(overflow_flag, 1'b0);
      chk(pwm_pos[1], 1'b0);
      chk(pwm_neg[1], 1'b1);
      chk(phase_out[2], 1'b1);
      // let the trough turn finish before the next stop
      repeat (3) @(posedge sys_clk);
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      chk(period_compare_a0, PERIOD_RST);
      for (int k = 0; k < NCH; k++) begin
         chk(general_out[k], GEN_RST);
      end
      chk({compare_flag_a, underflow_flag, overflow_flag}, 3'h0);
      // stopped pins follow the initial levels
      @(posedge sys_clk);
      pwm_mode_select <= MODE_RSYNC;
      pos_phase_init_level <= 1'b1;
      neg_phase_init_level <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(pwm_pos, 3'h7);
      chk(pwm_neg, 3'h7);
      // trough mode first: channel 0 still holds its reset override
      run_cpwm(MODE_CPWM_UDF);
      run_cpwm(MODE_CPWM_CM);
      chk(edges != 0, 1'b1);
      // reset synchronous count wraps at the period
      cfg(MODE_RSYNC, 16'h0003, 16'h0000, 16'h0000);
      @(posedge sys_clk);
      counter0_run <= 1'b1;
      wait_for(1'b0, 16'h0003);
      @(posedge sys_clk);
      #1;
      chk(counter_zero, 16'h0000);
      chk(compare_flag_a, 1'b1);
      // plain timer rolls over the ceiling
      cfg(MODE_TIMER, 16'hFFFE, 16'hFFFC, 16'h0000);
      @(posedge sys_clk);
      counter0_run <= 1'b1;
      wait_for(1'b0, CNT_ZERO);
      chk(overflow_flag, 1'b1);
      chk(compare_flag_a, 1'b1);
      results();
   end
endmodule // tb
